// [pkg/branch_pkg.sv]
// Constants for the flag-clear conditional branch decoder
package branch_pkg;
	localparam int          PC_WIDTH      = 21;
	localparam int          INSN_WIDTH    = 16;
	localparam int          OFFSET_WIDTH  = 8;
	localparam logic [3:0]  BR_GROUP      = 4'he;
	localparam logic [3:0]  NO_OVERFLOW_SUB  = 4'h5;
	localparam logic [3:0]  NONZERO_SUB      = 4'h1;
	localparam logic [3:0]  NON_NEGATIVE_SUB = 4'h7;
	localparam int          GROUP_MSB     = 15;
	localparam int          GROUP_LSB     = 12;
	localparam int          SUB_MSB       = 11;
	localparam int          SUB_LSB       = 8;
	localparam int          WORD_BYTES    = 2;
	localparam int          FLAG_N_BIT    = 4;
	localparam int          FLAG_OV_BIT   = 3;
	localparam int          FLAG_Z_BIT    = 2;
	localparam logic [1:0]  QUARTER_RESET = 2'h0;
	localparam logic [1:0]  Q1_CODE       = 2'h0;
	localparam logic [1:0]  Q2_CODE       = 2'h1;
	localparam logic [1:0]  Q3_CODE       = 2'h2;
	localparam logic [1:0]  Q4_CODE       = 2'h3;
endpackage : branch_pkg

// [verilog/branch_target.sv]
// Relative target adder: pc + 2n from a signed word offset
`timescale 1ns/1ns
module branch_target
	import branch_pkg::*;
#(
	parameter int W = PC_WIDTH
) (
	input  wire logic [W-1:0]            pc_i,
	input  wire logic [OFFSET_WIDTH-1:0] offset_i,
	output logic      [W-1:0]            target_o
);
	logic [W-1:0] ext_off;
	logic [W-1:0] byte_disp;

	// Sign extend first so backward branches wrap down [RQ13] [RQ2]
	assign ext_off   = {{(W-OFFSET_WIDTH){offset_i[OFFSET_WIDTH-1]}},
		offset_i};
	// Word count to byte displacement [RQ5]
	assign byte_disp = {ext_off[W-2:0], 1'b0};
	assign target_o  = pc_i + byte_disp;
endmodule : branch_target

// [verilog/cond_branch_exec.sv]
// Decode and Q1..Q4 execute of branches taken on a clear status flag
// Operation
// RQ1 - Not-overflow branch jumps when OV clear
// RQ2 - Offset signed, -128..127, low byte
// RQ3 - Not-overflow opcode is 1110 0101
// RQ4 - Status flags never changed by branch
// RQ5 - Offset doubled to bytes, two's complement
// RQ6 - Target is own address plus 2 plus 2n
// RQ7 - One word; one cycle, two if taken
// RQ8 - Taken: decode, read, process, write PC; nop
// RQ9 - Not taken: no PC write in Q4
// RQ10 - Flag set leaves PC at address plus 2
// RQ11 - Not-zero opcode 1110 0001, tests Z
// RQ12 - Not-negative opcode 1110 0111, tests N
// RQ13 - Offset sign-extended to PC width first
// RQ14 - Flag sampled before Q4 PC write
`timescale 1ns/1ns
module cond_branch_exec
	import branch_pkg::*;
#(
	parameter int W = PC_WIDTH
) (
	input  wire logic                  core_clk_i,
	input  wire logic                  rstn_i,
	input  wire logic [INSN_WIDTH-1:0] insn_i,
	input  wire logic                  insn_valid_i,
	input  wire logic [W-1:0]          pc_i,
	input  wire logic [7:0]            status_i,
	output logic      [1:0]            quarter_o,
	output logic                       busy_o,
	output logic                       flush_o,
	output logic                       pc_we_o,
	output logic      [W-1:0]          pc_o,
	output logic      [7:0]            status_o,
	output logic                       branch_taken_o,
	output logic                       branch_done_o
);
	typedef enum logic [5:0] {
		S_IDLE    = 6'h01,
		S_DECODE  = 6'h02,
		S_READ    = 6'h04,
		S_PROCESS = 6'h08,
		S_WRITE   = 6'h10,
		S_FLUSH   = 6'h20
	} state_t;

	state_t                  state_reg,   state_next;
	logic [1:0]              quarter_reg, quarter_next;
	logic [1:0]              flushq_reg,  flushq_next;
	logic [INSN_WIDTH-1:0]   insn_reg,    insn_next;
	logic [OFFSET_WIDTH-1:0] off_reg,     off_next;
	logic                    take_reg,    take_next;
	logic [W-1:0]            tgt_reg,     tgt_next;
	logic                    we_reg,      we_next;
	logic                    done_reg,    done_next;
	logic                    taken_reg,   taken_next;
	logic [W-1:0]            target;
	logic                    branch_no_overflow_op;
	logic                    branch_nonzero_op;
	logic                    branch_non_negative_op;
	logic                    flag_clear;

	////////////////////////////////////////////////////////////////////////
	// Decode
	logic [3:0] grp;
	logic [3:0] sub;
	assign grp = insn_reg[GROUP_MSB:GROUP_LSB];
	assign sub = insn_reg[SUB_MSB:SUB_LSB];
	assign branch_no_overflow_op  = (grp == BR_GROUP)
		&& (sub == NO_OVERFLOW_SUB);  // [RQ3]
	assign branch_nonzero_op      = (grp == BR_GROUP)
		&& (sub == NONZERO_SUB);      // [RQ11]
	assign branch_non_negative_op = (grp == BR_GROUP)
		&& (sub == NON_NEGATIVE_SUB); // [RQ12]

	// Flags are those left by the prior instruction [RQ14]
	always_comb begin
		flag_clear = 1'b0;
		if (branch_no_overflow_op)
			flag_clear = ~status_i[FLAG_OV_BIT]; // [RQ1]
		else if (branch_nonzero_op)
			flag_clear = ~status_i[FLAG_Z_BIT];  // [RQ11]
		else if (branch_non_negative_op)
			flag_clear = ~status_i[FLAG_N_BIT];  // [RQ12]
	end

	// pc_i already points past the branch word [RQ6]
	branch_target #(.W(W)) i_branch_target (
		.pc_i     (pc_i),
		.offset_i (off_reg),
		.target_o (target)
	);

	////////////////////////////////////////////////////////////////////////
	// Quarter sequencer
	always_comb begin
		state_next   = state_reg;
		quarter_next = quarter_reg;
		flushq_next  = flushq_reg;
		insn_next    = insn_reg;
		off_next     = off_reg;
		take_next    = take_reg;
		tgt_next     = tgt_reg;
		we_next      = 1'b0;
		done_next    = 1'b0;
		taken_next   = 1'b0;
		unique case (state_reg)
			S_IDLE: begin
				if (insn_valid_i) begin
					insn_next    = insn_i;
					quarter_next = Q1_CODE;
					state_next   = S_DECODE;
				end
			end
			S_DECODE: begin // [RQ8] [RQ9]
				quarter_next = Q2_CODE;
				state_next   = S_READ;
			end
			S_READ: begin
				off_next     = insn_reg[OFFSET_WIDTH-1:0]; // [RQ2]
				quarter_next = Q3_CODE;
				state_next   = S_PROCESS;
			end
			S_PROCESS: begin
				tgt_next     = target;
				take_next    = flag_clear;
				quarter_next = Q4_CODE;
				state_next   = S_WRITE;
			end
			S_WRITE: begin
				// Only a taken branch writes the PC [RQ8] [RQ9] [RQ10]
				we_next    = take_reg;
				taken_next = take_reg;
				if (take_reg) begin
					quarter_next = Q1_CODE;
					flushq_next  = Q1_CODE;
					state_next   = S_FLUSH; // [RQ7]
				end else begin
					done_next  = 1'b1;
					state_next = S_IDLE;
				end
			end
			S_FLUSH: begin
				// Second cycle idles all four quarters [RQ8] [RQ7]
				quarter_next = quarter_reg + 2'h1;
				flushq_next  = flushq_reg + 2'h1;
				if (flushq_reg == Q4_CODE) begin
					done_next  = 1'b1;
					state_next = S_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			state_reg   <= S_IDLE;
			quarter_reg <= QUARTER_RESET;
			flushq_reg  <= QUARTER_RESET;
			insn_reg    <= '0;
			off_reg     <= '0;
			take_reg    <= 1'b0;
			tgt_reg     <= '0;
			we_reg      <= 1'b0;
			done_reg    <= 1'b0;
			taken_reg   <= 1'b0;
		end else begin
			state_reg   <= state_next;
			quarter_reg <= quarter_next;
			flushq_reg  <= flushq_next;
			insn_reg    <= insn_next;
			off_reg     <= off_next;
			take_reg    <= take_next;
			tgt_reg     <= tgt_next;
			we_reg      <= we_next;
			done_reg    <= done_next;
			taken_reg   <= taken_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign quarter_o      = quarter_reg;
	assign busy_o         = (state_reg != S_IDLE);
	assign flush_o        = (state_reg == S_FLUSH);
	assign pc_we_o        = we_reg;
	// pc_o holds pc_i plus 2n even when not taken; pc_we_o stays low [RQ10]
	assign pc_o           = tgt_reg;
	// Flags pass straight through untouched [RQ4]
	assign status_o       = status_i;
	assign branch_taken_o = taken_reg;
	assign branch_done_o  = done_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	pc_write_taken_a: assert property (@(posedge core_clk_i) // [RQ1]
		disable iff (!rstn_i)
		(state_reg == S_WRITE) |=> (pc_we_o == $past(take_reg)))
		else $error("PC write does not follow branch decision");

	flush_len_a: assert property (@(posedge core_clk_i) // [RQ7]
		disable iff (!rstn_i)
		$rose(flush_o) |-> flush_o [*4] ##1 !flush_o)
		else $error("Flush cycle not four quarters");

	no_write_untaken_a: assert property (@(posedge core_clk_i) // [RQ9]
		disable iff (!rstn_i)
		(state_reg == S_WRITE && !take_reg) |=> !pc_we_o && !flush_o)
		else $error("Untaken branch wrote PC or flushed");

	target_value_a: assert property (@(posedge core_clk_i) // [RQ6]
		disable iff (!rstn_i)
		(state_reg == S_PROCESS) |=> tgt_reg == $past(pc_i)
			+ {{(W-OFFSET_WIDTH-1){off_reg[OFFSET_WIDTH-1]}}, off_reg,
			1'b0})
		else $error("Target not pc plus twice offset");

	quarter_seq_a: assert property (@(posedge core_clk_i) // [RQ8]
		disable iff (!rstn_i)
		(state_reg == S_DECODE) |-> quarter_o == Q1_CODE
			##1 quarter_o == Q2_CODE ##1 quarter_o == Q3_CODE
			##1 quarter_o == Q4_CODE)
		else $error("Quarter sequence broken");

	flags_kept_a: assert property (@(posedge core_clk_i) // [RQ4]
		disable iff (!rstn_i)
		busy_o |-> status_o == status_i)
		else $error("Status changed by branch");

	decode_ov_a: assert property (@(posedge core_clk_i) // [RQ3]
		disable iff (!rstn_i)
		(state_reg == S_PROCESS
			&& insn_reg[GROUP_MSB:SUB_LSB] == {BR_GROUP, NO_OVERFLOW_SUB}
			&& status_i[FLAG_OV_BIT]) |=> !take_reg)
		else $error("Overflow set but branch taken");

	decode_z_a: assert property (@(posedge core_clk_i) // [RQ11]
		disable iff (!rstn_i)
		(state_reg == S_PROCESS
			&& insn_reg[GROUP_MSB:SUB_LSB] == {BR_GROUP, NONZERO_SUB})
			|=> take_reg == !$past(status_i[FLAG_Z_BIT]))
		else $error("Zero branch decision wrong");

	decode_n_a: assert property (@(posedge core_clk_i) // [RQ12]
		disable iff (!rstn_i)
		(state_reg == S_PROCESS
			&& insn_reg[GROUP_MSB:SUB_LSB] == {BR_GROUP, NON_NEGATIVE_SUB})
			|=> take_reg == !$past(status_i[FLAG_N_BIT]))
		else $error("Negative branch decision wrong");
endmodule : cond_branch_exec

// [bench/tb_cond_branch_flag_clear_exec.sv]
// Self-checking bench for the flag-clear conditional branch decoder
`timescale 1ns/1ns
module tb_cond_branch_flag_clear_exec import branch_pkg::*;;
	logic                  core_clk_i;
	logic                  rstn_i;
	logic [INSN_WIDTH-1:0] insn_i;
	logic                  insn_valid_i;
	logic [PC_WIDTH-1:0]   pc_i;
	logic [7:0]            status_i;
	logic [1:0]            quarter_o;
	logic                  busy_o;
	logic                  flush_o;
	logic                  pc_we_o;
	logic [PC_WIDTH-1:0]   pc_o;
	logic [7:0]            status_o;
	logic                  branch_taken_o;
	logic                  branch_done_o;
	int                    err_total;
	int                    comparisons;

	cond_branch_exec #(.W(PC_WIDTH)) i_cond_branch_exec (
		.core_clk_i     (core_clk_i),
		.rstn_i         (rstn_i),
		.insn_i         (insn_i),
		.insn_valid_i   (insn_valid_i),
		.pc_i           (pc_i),
		.status_i       (status_i),
		.quarter_o      (quarter_o),
		.busy_o         (busy_o),
		.flush_o        (flush_o),
		.pc_we_o        (pc_we_o),
		.pc_o           (pc_o),
		.status_o       (status_o),
		.branch_taken_o (branch_taken_o),
		.branch_done_o  (branch_done_o)
	);

	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	task automatic results();
		if (err_total == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	////////////////////////////////////////////////////////////////////////
	// One instruction, issued at a falling edge, judged cycle by cycle
	task automatic run(input logic [15:0] w, input logic [PC_WIDTH-1:0] pc,
		input logic [7:0] st, input logic take);
		logic [PC_WIDTH-1:0] tgt;
		int                  k;
		int                  flushes;
		int                  we_k;
		int                  taken_k;
		int                  done_k;
		tgt = pc + ({{(PC_WIDTH-8){w[7]}}, w[7:0]} << 1);
		flushes = 0;
		we_k = -1;
		taken_k = -1;
		done_k = -1;
		insn_i = w;
		pc_i = pc;
		status_i = st;
		insn_valid_i = 1'b1;
		@(posedge core_clk_i);
		for (k = 0; k < 20 && done_k < 0; k++) begin
			@(negedge core_clk_i);
			if (k == 0) insn_valid_i = 1'b0;
			chk("status_o", st, status_o);
			if (flush_o === 1'b1) flushes++;
			if (branch_taken_o === 1'b1) taken_k = k;
			if (pc_we_o === 1'b1) begin
				we_k = k;
				chk("pc_o", tgt, pc_o);
			end
			if (branch_done_o === 1'b1) begin
				done_k = k;
				chk("busy_o", 0, busy_o);
			end else begin
				chk("busy_o", 1, busy_o);
				chk("quarter_o", k % 4, quarter_o);
			end
		end
		if (done_k < 0) begin
			err_total++;
			results();
		end
		chk("done cycle", take ? 8 : 4, done_k);
		chk("write cycle", take ? 4 : -1, we_k);
		chk("taken cycle", take ? 4 : -1, taken_k);
		chk("flush cycles", take ? 4 : 0, flushes);
	endtask : run

	////////////////////////////////////////////////////////////////////////
	// Scenarios; each starts at the falling edge where the last one ended
	task automatic s_no_overflow();
		run(16'he57f, 21'h001000, 8'h14, 1'b1);
		run(16'he57f, 21'h001000, 8'h08, 1'b0);
	endtask : s_no_overflow

	task automatic s_nonzero();
		// Low PC with the most negative offset wraps the full width
		run(16'he180, 21'h000040, 8'h18, 1'b1);
		run(16'he180, 21'h000040, 8'h04, 1'b0);
		run(16'he1ff, 21'h1fffff, 8'h00, 1'b1);
	endtask : s_nonzero

	task automatic s_non_negative();
		run(16'he701, 21'h0abcde, 8'h0c, 1'b1);
		run(16'he701, 21'h0abcde, 8'h10, 1'b0);
	endtask : s_non_negative

	task automatic s_foreign_words();
		// Neighbouring encodings must never write the PC
		run(16'he37f, 21'h000200, 8'h00, 1'b0);
		run(16'hd57f, 21'h000200, 8'h00, 1'b0);
		run(16'he47f, 21'h000200, 8'h00, 1'b0);
	endtask : s_foreign_words

	task automatic s_mid_reset();
		// Reset in mid-instruction must abandon it with no PC write
		insn_i = 16'he57f;
		pc_i = 21'h000300;
		status_i = 8'h00;
		insn_valid_i = 1'b1;
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		insn_valid_i = 1'b0;
		@(negedge core_clk_i);
		rstn_i = 1'b0;
		@(negedge core_clk_i);
		chk("busy_o", 0, busy_o);
		chk("pc_we_o", 0, pc_we_o);
		chk("flush_o", 0, flush_o);
		rstn_i = 1'b1;
		run(16'he57f, 21'h000300, 8'h00, 1'b1);
	endtask : s_mid_reset

	initial begin
		err_total = 0;
		comparisons = 0;
		rstn_i = 1'b0;
		insn_i = 16'h0000;
		insn_valid_i = 1'b0;
		pc_i = 21'h000000;
		status_i = 8'h00;
		repeat (10) @(negedge core_clk_i);
		chk("busy_o", 0, busy_o);
		chk("quarter_o", 0, quarter_o);
		rstn_i = 1'b1;
		s_no_overflow();
		s_nonzero();
		s_non_negative();
		s_foreign_words();
		s_mid_reset();
		results();
	end
endmodule : tb_cond_branch_flag_clear_exec
